//--- rtl/pfc_unit.v
// Privilege state, stack select and bus function code unit
//
// Functional notes
// - Supervisor bit high means supervisor state
// - Drive three-bit function code every core cycle
// - DMA and refresh masters drive their codes
// - Decode function codes from external masters
// - Exception entry forces supervisor state
// - Exception bus cycles use supervisor codes
// - Exception stacking uses supervisor stack pointer
// - Halt and device reset refused in user
// - Whole status word writes need supervisor
// - User stack pointer moves are privileged
// - Supervisor instruction cycles get supervisor codes
// - Stack/register seven selects pointer by state
// - User to supervisor only via exceptions
// - Save old status word, then set supervisor
// - Four instructions may drop to user state
// - Exception steps: copy, vector, save, load
// - Interrupt acknowledge uses CPU space code
// - Immediate AND/OR/XOR on flags or whole word
`timescale 1ns/100ps
`include "pfc_consts.vh"
module pfc_unit
(
  sys_clk,
  rstn,
  op_valid,
  op_class,
  op_imm,
  exc_req,
  exc_is_int,
  exc_step_done,
  ret_word,
  bus_cycle,
  bus_program,
  bus_master,
  bus_int_ack,
  ext_fc_pin,
  status_word,
  supervisor,
  use_priv_sp,
  access_class,
  op_accept,
  op_refuse,
  halt_req,
  dev_reset_req,
  priv_violation,
  exc_step,
  saved_status_word,
  ext_class_valid,
  ext_supervisor,
  ext_program,
  ext_cpu_space
);
  input              sys_clk;
  input              rstn;
  input              op_valid;
  input  [3:0]       op_class;
  input  [15:0]      op_imm;
  input              exc_req;
  input              exc_is_int;
  input              exc_step_done;
  input  [15:0]      ret_word;
  input              bus_cycle;
  input              bus_program;
  input  [2:0]       bus_master;
  input              bus_int_ack;
  input  [2:0]       ext_fc_pin;
  output [15:0]      status_word;
  output             supervisor;
  output             use_priv_sp;
  output [2:0]       access_class;
  output             op_accept;
  output             op_refuse;
  output             halt_req;
  output             dev_reset_req;
  output             priv_violation;
  output [3:0]       exc_step;
  output [15:0]      saved_status_word;
  output             ext_class_valid;
  output             ext_supervisor;
  output             ext_program;
  output             ext_cpu_space;

  // ----------------------------------------------------------------
  // Exception sequencer states
  // ----------------------------------------------------------------
  localparam [4:0] ST_IDLE   = 5'b0_0001;
  localparam [4:0] ST_COPY   = 5'b0_0010;
  localparam [4:0] ST_VECTOR = 5'b0_0100;
  localparam [4:0] ST_SAVE   = 5'b0_1000;
  localparam [4:0] ST_LOAD   = 5'b1_0000;

  reg  [15:0]        sw_q;
  reg  [15:0]        sw_d;
  reg  [15:0]        saved_q;
  reg  [4:0]         st_q;
  reg  [4:0]         st_d;
  reg                pend_q;
  reg                pend_int_q;
  reg                pend_viol_q;
  reg  [2:0]         fc_q;
  reg  [2:0]         fc_d;
  reg                sp_q;
  reg                accept_q;
  reg                refuse_q;
  reg                halt_q;
  reg                devrst_q;
  reg                viol_q;
  reg  [2:0]         ext_sync1_q;
  reg  [2:0]         ext_sync2_q;
  reg                ext_valid_q;
  reg                ext_sup_q;
  reg                ext_prog_q;
  reg                ext_cpu_q;
  wire               sup_now;
  wire               in_exc;
  wire               privileged;
  wire               take_op;
  wire               bad_op;

  assign sup_now  = sw_q[`PFC_SW_S_BIT];
  assign in_exc   = ~st_q[0];
  assign privileged = (op_class == `PFC_OP_HALT) ||
                      (op_class == `PFC_OP_DEV_RESET) ||
                      (op_class == `PFC_OP_LOAD_SW) ||
                      (op_class == `PFC_OP_AND_SW) ||
                      (op_class == `PFC_OP_OR_SW) ||
                      (op_class == `PFC_OP_XOR_SW) ||
                      (op_class == `PFC_OP_RETURN_EXC) ||
                      (op_class == `PFC_OP_USP_MOVE);
  assign take_op  = op_valid & ~in_exc;
  assign bad_op   = take_op & privileged & ~sup_now;

  // ----------------------------------------------------------------
  // Exception sequencer
  // ----------------------------------------------------------------
  always @*
  begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:
      begin
        if (exc_req | bad_op)
          st_d = ST_COPY;
      end
      ST_COPY:   st_d = ST_VECTOR;
      ST_VECTOR:
      begin
        if (exc_step_done)
          st_d = ST_SAVE;
      end
      ST_SAVE:
      begin
        if (exc_step_done)
          st_d = ST_LOAD;
      end
      ST_LOAD:
      begin
        if (exc_step_done)
          st_d = ST_IDLE;
      end
      default:   st_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Status word update
  // ----------------------------------------------------------------
  always @*
  begin
    sw_d = sw_q;
    if (st_q == ST_COPY)
      sw_d[`PFC_SW_S_BIT] = 1'b1;
    else if (take_op & ~bad_op)
    begin
      case (op_class)
        `PFC_OP_LOAD_SW:    sw_d = op_imm;
        `PFC_OP_AND_SW:     sw_d = sw_q & op_imm;
        `PFC_OP_OR_SW:      sw_d = sw_q | op_imm;
        `PFC_OP_XOR_SW:     sw_d = sw_q ^ op_imm;
        `PFC_OP_RETURN_EXC: sw_d = ret_word;
        `PFC_OP_AND_CCR:    sw_d = sw_q & (op_imm | ~`PFC_SW_CCR_MASK);
        `PFC_OP_OR_CCR:     sw_d = sw_q | (op_imm & `PFC_SW_CCR_MASK);
        `PFC_OP_XOR_CCR:    sw_d = sw_q ^ (op_imm & `PFC_SW_CCR_MASK);
        `PFC_OP_LOAD_CCR:
          sw_d = (sw_q & ~`PFC_SW_CCR_MASK) | (op_imm & `PFC_SW_CCR_MASK);
        default:            sw_d = sw_q;
      endcase
      if (~sup_now)
        sw_d[`PFC_SW_S_BIT] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Function code selection
  // ----------------------------------------------------------------
  always @*
  begin
    fc_d = `PFC_FC_NONE;
    if (bus_cycle)
    begin
      case (bus_master)
        `PFC_MST_CORE:
        begin
          if (bus_int_ack)
            fc_d = `PFC_FC_CPU_SPACE;
          else if (sup_now | in_exc)
            fc_d = bus_program ? `PFC_FC_SUPV_PROG : `PFC_FC_SUPV_DATA;
          else
            fc_d = bus_program ? `PFC_FC_USER_PROG : `PFC_FC_USER_DATA;
        end
        `PFC_MST_BLK_DMA,
        `PFC_MST_SER_DMA,
        `PFC_MST_REFRESH:
          fc_d = bus_program ? `PFC_FC_SUPV_PROG : `PFC_FC_SUPV_DATA;
        default: fc_d = `PFC_FC_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and status registers
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      sw_q        <= `PFC_SW_RESET;
      saved_q     <= 16'h0000;
      st_q        <= ST_IDLE;
      pend_q      <= 1'b0;
      pend_int_q  <= 1'b0;
      pend_viol_q <= 1'b0;
      sp_q        <= 1'b1;
    end
    else
    begin
      st_q     <= st_d;
      sw_q     <= sw_d;
      if ((st_q == ST_IDLE) && st_d[1])
      begin
        pend_viol_q <= bad_op;
        pend_int_q  <= exc_is_int & ~bad_op;
      end
      if (st_q == ST_COPY)
        saved_q <= sw_q;
      pend_q   <= in_exc;
      sp_q     <= sw_d[`PFC_SW_S_BIT] | st_d[1] | in_exc;
    end
  end

  // ----------------------------------------------------------------
  // Function code register
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      fc_q     <= `PFC_FC_NONE;
    end
    else
    begin
      fc_q     <= fc_d;
    end
  end

  // ----------------------------------------------------------------
  // Instruction result pulses
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      accept_q <= 1'b0;
      refuse_q <= 1'b0;
      halt_q   <= 1'b0;
      devrst_q <= 1'b0;
      viol_q   <= 1'b0;
    end
    else
    begin
      accept_q <= take_op & ~bad_op;
      refuse_q <= bad_op;
      viol_q   <= bad_op;
      halt_q   <= take_op & ~bad_op & (op_class == `PFC_OP_HALT);
      devrst_q <= take_op & ~bad_op & (op_class == `PFC_OP_DEV_RESET);
    end
  end

  // ----------------------------------------------------------------
  // External code synchroniser
  // ----------------------------------------------------------------
  // Pins are asynchronous; only the second stage feeds the decode
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ext_sync1_q <= 3'h0;
      ext_sync2_q <= 3'h0;
    end
    else
    begin
      ext_sync1_q <= ext_fc_pin;
      ext_sync2_q <= ext_sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // External code decode
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ext_valid_q <= 1'b0;
      ext_sup_q   <= 1'b0;
      ext_prog_q  <= 1'b0;
      ext_cpu_q   <= 1'b0;
    end
    else
    begin
      ext_valid_q <= (ext_sync2_q == `PFC_FC_USER_DATA) |
                     (ext_sync2_q == `PFC_FC_USER_PROG) |
                     (ext_sync2_q == `PFC_FC_SUPV_DATA) |
                     (ext_sync2_q == `PFC_FC_SUPV_PROG) |
                     (ext_sync2_q == `PFC_FC_CPU_SPACE);
      // Unassigned codes never count as supervisor
      ext_sup_q   <= (ext_sync2_q == `PFC_FC_SUPV_DATA) |
                     (ext_sync2_q == `PFC_FC_SUPV_PROG) |
                     (ext_sync2_q == `PFC_FC_CPU_SPACE);
      ext_prog_q  <= (ext_sync2_q == `PFC_FC_USER_PROG) |
                     (ext_sync2_q == `PFC_FC_SUPV_PROG);
      ext_cpu_q   <= (ext_sync2_q == `PFC_FC_CPU_SPACE);
    end
  end

  assign status_word       = sw_q;
  assign supervisor        = sw_q[`PFC_SW_S_BIT];
  assign use_priv_sp       = sp_q;
  assign access_class      = fc_q;
  assign op_accept         = accept_q;
  assign op_refuse         = refuse_q;
  assign halt_req          = halt_q;
  assign dev_reset_req     = devrst_q;
  assign priv_violation    = viol_q;
  assign exc_step          = st_q[4:1];
  assign saved_status_word = saved_q;
  assign ext_class_valid   = ext_valid_q;
  assign ext_supervisor    = ext_sup_q;
  assign ext_program       = ext_prog_q;
  assign ext_cpu_space     = ext_cpu_q;
endmodule

//--- rtl/pfc_consts.vh
// Constants for the privilege and function code unit
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH
// Function code values
`define PFC_FC_USER_DATA   3'h1
`define PFC_FC_USER_PROG   3'h2
`define PFC_FC_SUPV_DATA   3'h5
`define PFC_FC_SUPV_PROG   3'h6
`define PFC_FC_CPU_SPACE   3'h7
`define PFC_FC_NONE        3'h0
// Status word layout
`define PFC_SW_S_BIT       13
`define PFC_SW_RESET       16'h2700
`define PFC_SW_CCR_MASK    16'h00ff
// Instruction class codes
`define PFC_OP_NONE        4'h0
`define PFC_OP_HALT        4'h1
`define PFC_OP_DEV_RESET   4'h2
`define PFC_OP_LOAD_SW     4'h3
`define PFC_OP_AND_SW      4'h4
`define PFC_OP_OR_SW       4'h5
`define PFC_OP_XOR_SW      4'h6
`define PFC_OP_RETURN_EXC  4'h7
`define PFC_OP_USP_MOVE    4'h8
`define PFC_OP_AND_CCR     4'h9
`define PFC_OP_OR_CCR      4'ha
`define PFC_OP_XOR_CCR     4'hb
`define PFC_OP_LOAD_CCR    4'hc
// Bus master select
`define PFC_MST_CORE       3'h0
`define PFC_MST_BLK_DMA    3'h1
`define PFC_MST_SER_DMA    3'h2
`define PFC_MST_REFRESH    3'h3
`define PFC_MST_EXTERNAL   3'h4
`endif

//--- verification/pfc_unit_monitor.sv
// Assertion checker for the privilege and function code unit
`timescale 1ns/100ps
`include "pfc_consts.vh"
module pfc_unit_monitor
(
  input logic        sys_clk,
  input logic        rstn,
  input logic        op_valid,
  input logic [3:0]  op_class,
  input logic        exc_req,
  input logic        bus_cycle,
  input logic        bus_program,
  input logic [2:0]  bus_master,
  input logic        bus_int_ack,
  input logic [15:0] status_word,
  input logic        supervisor,
  input logic        use_priv_sp,
  input logic [2:0]  access_class,
  input logic        op_accept,
  input logic        op_refuse,
  input logic        halt_req,
  input logic        dev_reset_req,
  input logic        priv_violation,
  input logic [3:0]  exc_step,
  input logic [15:0] saved_status_word
);
  // ----------------
  // Privilege checks
  // ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire idle = exc_step == 4'h0;
  wire priv_op = op_valid && idle && !supervisor && op_class != 4'h0 && op_class <= 4'h8;
  wire exc_go = exc_req && idle && !op_valid;
  wire drop_op = op_valid && idle && (op_class == 4'h3 || op_class == 4'h4
    || op_class == 4'h6 || op_class == 4'h7);
  wire core_bus = bus_cycle && bus_master == `PFC_MST_CORE && !bus_int_ack;
  property p_refuse; priv_op |=> op_refuse && priv_violation && !op_accept; endproperty
  a_refuse: assert property (p_refuse) else $error("op not refused");
  property p_nohalt; priv_op |=> !halt_req && !dev_reset_req; endproperty
  a_nohalt: assert property (p_nohalt) else $error("halt in user");
  property p_enter; exc_go |=> exc_step == 4'h1 ##1 (exc_step == 4'h2 && supervisor); endproperty
  a_enter: assert property (p_enter) else $error("bad entry");
  property p_saved; exc_go |=> ##1 saved_status_word == $past(status_word, 2); endproperty
  a_saved: assert property (p_saved) else $error("bad saved word");
  property p_ssp; exc_step[3:1] != 3'h0 |-> use_priv_sp && supervisor; endproperty
  a_ssp: assert property (p_ssp) else $error("bad stack select");
  property p_rise; $rose(supervisor) |-> $past(exc_step) == 4'h1; endproperty
  a_rise: assert property (p_rise) else $error("bad rise");
  property p_fall; $fell(supervisor) |-> $past(drop_op); endproperty
  a_fall: assert property (p_fall) else $error("bad drop");
  property p_fc;
    core_bus |=> access_class == {$past(supervisor) || $past(exc_step) != 4'h0,
      $past(bus_program), !$past(bus_program)};
  endproperty
  a_fc: assert property (p_fc) else $error("bad code");
  c_priv: cover property (priv_op);
  c_exc: cover property (exc_go);
  c_fall: cover property ($fell(supervisor));
endmodule
bind pfc_unit pfc_unit_monitor u_mon (.*);

//--- verification/pfc_ext_agent.sv
// Partner model of an external bus master
`timescale 1ns/100ps
module pfc_ext_agent
(
  input  logic       sys_clk,
  input  logic [2:0] code,
  output logic [2:0] ext_fc_pin
);
  // --------------------------
  // Pins move at falling edges
  // --------------------------
  always @(negedge sys_clk) ext_fc_pin <= code;
endmodule

//--- verification/pfc_unit_tb.sv
// Testbench for the privilege and function code unit
`timescale 1ns/100ps
`include "pfc_consts.vh"
module pfc_unit_tb;
  logic        sys_clk, rstn, op_valid, exc_req, exc_is_int, exc_step_done;
  logic        bus_cycle, bus_program, bus_int_ack;
  logic [3:0]  op_class;
  logic [15:0] op_imm, ret_word, sw;
  logic [2:0]  bus_master, code;
  logic [31:0] rnd;
  int          i, k, n_errors, cmp_count;
  wire  [15:0] status_word, saved_status_word;
  wire  [3:0]  exc_step;
  wire  [2:0]  access_class, ext_fc_pin;
  wire         supervisor, use_priv_sp, op_accept, op_refuse, halt_req, dev_reset_req;
  wire         priv_violation, ext_class_valid, ext_supervisor, ext_program, ext_cpu_space;
  logic [3:0]  drops [4] = '{4'h3, 4'h4, 4'h6, 4'h7};
  pfc_unit uut (.*);
  pfc_ext_agent agent (.sys_clk(sys_clk), .code(code), .ext_fc_pin(ext_fc_pin));
  // -------------------
  // Helpers
  // -------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] flags(input logic [3:0] c, input logic [7:0] f, v);
    return c == 4'h9 ? f & v : c == 4'ha ? f | v : c == 4'hb ? f ^ v : v;
  endfunction
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic do_op(input logic [3:0] c, input logic [15:0] v);
    {op_valid, op_class, op_imm} = {1'b1, c, v};
    @(negedge sys_clk);
    op_valid = 1'b0;
  endtask
  task automatic bus_sweep;
    for (int j = 0; j < 24; j++)
    begin
      rnd = lfsr(rnd);
      {bus_cycle, bus_master, bus_program} = {1'b1, 1'b0, rnd[1:0], rnd[2]};
      bus_int_ack = rnd[4:3] == 2'h3 && bus_master == 3'h0;
      @(negedge sys_clk);
      chk(access_class === (bus_int_ack ? 3'h7 : {supervisor || bus_master != 3'h0,
        bus_program, !bus_program}), "function code");
    end
    bus_cycle = 1'b0;
    @(negedge sys_clk);
    chk(access_class === 3'h0, "idle code");
  endtask
  task automatic finish_exc(input logic [15:0] old);
    for (k = 0; exc_step !== 4'h2; k++)
    begin
      if (k == 10)
      begin
        chk(1'b0, "exception wait timed out");
        results();
      end
      @(negedge sys_clk);
    end
    chk(supervisor === 1'b1 && use_priv_sp === 1'b1 && saved_status_word === old, "entry");
    {bus_cycle, bus_master, bus_program} = {1'b1, 3'h0, rnd[5]};
    do_op(4'h3, 16'h0000);
    bus_cycle = 1'b0;
    chk(access_class[2] === 1'b1 && op_accept === 1'b0, "busy cycle");
    for (int j = 0; j < 3; j++)
    begin
      exc_step_done = 1'b1;
      @(negedge sys_clk);
      exc_step_done = 1'b0;
      chk(exc_step === (4'h4 << j), "step order");
    end
  endtask
  // -------------------
  // Stimulus
  // -------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    {rstn, op_valid, exc_req, exc_is_int, exc_step_done, bus_cycle, bus_program} = 7'h00;
    {bus_int_ack, op_class, op_imm, ret_word, bus_master, code} = 39'h0;
    {rnd, n_errors, cmp_count} = {32'he970_864b, 64'h0};
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    chk(status_word === 16'h2700 && use_priv_sp === 1'b1 && exc_step === 4'h0
      && access_class === 3'h0, "reset");
    bus_sweep();
    for (i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      ret_word = rnd[31:16] & 16'hdfff;
      do_op(drops[i % 4], i % 4 == 2 ? rnd[15:0] | 16'h2000 : rnd[15:0] & 16'hdfff);
      chk(op_accept === 1'b1 && supervisor === 1'b0 && use_priv_sp === 1'b0, "drop");
      sw = status_word;
      do_op(4'h9 + 4'(i % 4), rnd[31:16]);
      chk(status_word === {sw[15:8], flags(4'h9 + 4'(i % 4), sw[7:0], rnd[23:16])},
        "flag op");
      bus_sweep();
      sw = status_word;
      do_op(4'(i + 1), rnd[15:0] | 16'h2000);
      chk(op_refuse === 1'b1 && priv_violation === 1'b1 && op_accept === 1'b0
        && halt_req === 1'b0 && dev_reset_req === 1'b0 && supervisor === 1'b0, "refuse");
      finish_exc(sw);
    end
    do_op(4'h3, 16'h0000);
    sw = status_word;
    {exc_req, exc_is_int} = {1'b1, rnd[9]};
    @(negedge sys_clk);
    exc_req = 1'b0;
    chk(exc_step === 4'h1, "copy step");
    finish_exc(sw);
    for (i = 0; i < 8; i++)
    begin
      code <= 3'(i);
      repeat (6) @(negedge sys_clk);
      chk(ext_class_valid === (i inside {1, 2, 5, 6, 7}) && ext_cpu_space === (i == 7)
        && ext_program === (i == 2 || i == 6) && ext_supervisor === (i inside {5, 6, 7}),
        "ext decode");
    end
    results();
  end
endmodule
